// ---- mbpu_addr_decode.sv ----
// Purpose: Register address decoder with jumper inputs
// Assumes: Jumper levels are already synchronised in the parent
// Notes: Jumper installed reads as level 1
`timescale 1ns/1ns
module mbpu_addr_decode (
  input wire logic [17:0] busAddr,
  input wire logic [2:0] baseSelectLevels,
  input wire logic lowSelectJumperIn,
  output logic addrHit
);
  logic highOk;
  logic selOk;
  logic lowOk;
  // ==========================================================
  // Fixed high pattern, jumper compare and bit 1 select
  assign highOk = (busAddr[17:mbpu_pkg::MBPU_ADDR_HIGH_LSB] == mbpu_pkg::MBPU_ADDR_HIGH);
  assign selOk = (busAddr[4:mbpu_pkg::MBPU_ADDR_SEL_LSB] == baseSelectLevels);
  assign lowOk = (busAddr[1] == ~lowSelectJumperIn);
  // Word aligned only: bit 0 must be clear
  assign addrHit = highOk & selOk & lowOk & ~busAddr[0];
endmodule : mbpu_addr_decode

// ---- mbpu_byte_parity.sv ----
// Purpose: Nine-input parity for one byte plus one extra bit
// Assumes: Pure combinational
// Notes: Output high when the count of ones is odd
`timescale 1ns/1ns
module mbpu_byte_parity (
  input wire logic [7:0] dataByte,
  input wire logic extraBit,
  output logic oddOut
);
  // ==========================================================
  // Reduction gives odd-count indication
  assign oddOut = ^{dataByte, extraBit};
endmodule : mbpu_byte_parity

// ---- mbpu_parity_unit.sv ----
// Function
// - Address bits 17-5 match a fixed pattern
// - Address bits 4-2 equal base jumpers
// - Bit 1 zero if jumper in, else one
// - Access needs master sync and enable jumper cut
// - Acknowledge on any matched cycle type
// - Register address mirrors starting address bits
// - Report enable written and read at bit 0
// - Force bad parity written from bit 2
// - Error seen written from bit 15
// - Error seen set on any fast-bus read error
// - Error seen set only at cycle done
// - Error flag needs error and report enable
// - Each byte plus parity checked even
// - Parity bits 16 low, 17 high byte
// - Force bad parity makes stored parity odd
// - Parity latches track until data latch
// - Only fast-bus reads load check register
// - Error flag needs request and control ok
// - Read gates register, write pulses strobe
// - Register accepts whole-word accesses only
//
// Purpose: Parity register, write parity generator and read checker
// Assumes: Bus and memory control levels are in the clk_sys domain
// Notes: Jumper levels are pins and pass a three-stage filter
`timescale 1ns/1ns
module mbpu_parity_unit (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [17:0] busAddr,
  input wire logic [15:0] busDataIn,
  input wire mbpu_pkg::mbpu_cycle_e busCycle,
  input wire logic masterSyncDerivative,
  input wire logic [2:0] baseSelectLevelsPin,
  input wire logic lowSelectJumperInPin,
  input wire logic enableJumperInPin,
  input wire logic [15:0] writeData,
  input wire logic writeByte,
  input wire logic dataLatchControl,
  input wire logic [17:0] memReadData,
  input wire logic fastRead,
  input wire logic cycleDone,
  input wire logic processorRequest,
  input wire logic controlOk,
  output logic [15:0] busDataOut,
  output logic registerReadGate,
  output logic registerAcknowledge,
  output logic registerWriteStrobe,
  output logic [1:0] memParityOut,
  output logic parityErrorFlag,
  output logic errorSeenBit,
  output logic forceBadParityBit,
  output logic errorReportEnableBit
);
  // ==========================================================
  // Jumper pin synchronisers
  logic [4:0] jmpS1;
  logic [4:0] jmpS2;
  logic [4:0] jmpS3;
  logic [4:0] jmpStable;
  // Three stages, accepted when second and third agree
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      jmpS1 <= 5'h10; // Same as filter reset, so no false agreement
      jmpS2 <= 5'h10;
      jmpS3 <= 5'h10;
    end else begin
      jmpS1 <= {enableJumperInPin, lowSelectJumperInPin, baseSelectLevelsPin};
      jmpS2 <= jmpS1;
      jmpS3 <= jmpS2;
    end
  end
  // Filter per bit; reset value reads as enable jumper in, so register access stays blocked
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      jmpStable <= 5'h10;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (jmpS2[i] == jmpS3[i]) begin
          jmpStable[i] <= jmpS3[i];
        end
      end
    end
  end
  // ==========================================================
  // Address decode
  logic addrHit;
  logic accessOk;
  logic isWrite;
  logic isRead;
  // Jumpers set so bits 4:1 track starting address bits 17:14
  mbpu_addr_decode u_decode (
    .busAddr(busAddr),
    .baseSelectLevels(jmpStable[2:0]),
    .lowSelectJumperIn(jmpStable[3]),
    .addrHit(addrHit)
  );
  // Installed enable jumper blocks every access
  assign accessOk = addrHit & masterSyncDerivative & ~jmpStable[4];
  // Byte write to the register is not a whole-word access
  assign isWrite = (busCycle == mbpu_pkg::MBPU_CYC_WRITE);
  assign isRead = (busCycle == mbpu_pkg::MBPU_CYC_READ) ||
    (busCycle == mbpu_pkg::MBPU_CYC_READ_PAUSE);
  logic syncSeen;
  // Edge of sync gives a one-cycle write strobe per bus cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      syncSeen <= 1'b0;
    end else begin
      syncSeen <= accessOk;
    end
  end
  // ==========================================================
  // Bus handshake outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      registerAcknowledge <= 1'b0;
      registerReadGate <= 1'b0;
      registerWriteStrobe <= 1'b0;
    end else begin
      registerAcknowledge <= accessOk;
      registerReadGate <= accessOk & isRead;
      registerWriteStrobe <= accessOk & ~syncSeen & isWrite;
    end
  end
  // ==========================================================
  // Read-back data, report enable, force bad parity and error seen bits only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busDataOut <= 16'h0000;
    end else begin
      busDataOut <= 16'h0000;
      if (accessOk && isRead) begin
        busDataOut[mbpu_pkg::MBPU_BIT_REPORT_EN] <= errorReportEnableBit;
        busDataOut[mbpu_pkg::MBPU_BIT_FORCE_BAD] <= forceBadParityBit;
        busDataOut[mbpu_pkg::MBPU_BIT_ERR_SEEN] <= errorSeenBit;
      end
    end
  end
  // ==========================================================
  // Register bits
  logic writeNow;
  assign writeNow = accessOk & ~syncSeen & isWrite;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      errorReportEnableBit <= mbpu_pkg::MBPU_RST_REPORT_EN;
      forceBadParityBit <= mbpu_pkg::MBPU_RST_FORCE_BAD;
    end else if (writeNow) begin
      errorReportEnableBit <= busDataIn[mbpu_pkg::MBPU_BIT_REPORT_EN];
      forceBadParityBit <= busDataIn[mbpu_pkg::MBPU_BIT_FORCE_BAD];
    end
  end
  // ==========================================================
  // Read checker on the data out register
  logic [17:0] checkReg;
  logic [1:0] byteBad;
  logic badParityDetected;
  logic doneSeen;
  logic errorSeenSet;
  // Unibus reads never load, so they cannot raise errors
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      checkReg <= 18'h00000;
    end else if (fastRead && dataLatchControl) begin
      checkReg <= memReadData;
    end
  end
  genvar g;
  for (g = 0; g < 2; g++) begin : gen_check
    mbpu_byte_parity u_chk (
      .dataByte(checkReg[g*8 +: 8]),
      .extraBit(checkReg[16+g]),
      .oddOut(byteBad[g])
    );
  end
  // Either byte bad has the same effect
  assign badParityDetected = |byteBad;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      doneSeen <= 1'b0;
    end else begin
      doneSeen <= cycleDone;
    end
  end
  // Set pulse on rise of cycle done, fast-bus reads only
  assign errorSeenSet = badParityDetected & cycleDone & ~doneSeen & fastRead;
  // Hardware set wins over a software write in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      errorSeenBit <= mbpu_pkg::MBPU_RST_ERR_SEEN;
    end else if (errorSeenSet) begin
      errorSeenBit <= 1'b1;
    end else if (writeNow) begin
      errorSeenBit <= busDataIn[mbpu_pkg::MBPU_BIT_ERR_SEEN];
    end
  end
  // ==========================================================
  // Error flag; may fluctuate while control ok is high, valid at its fall
  logic errorFlagStrobe;
  assign errorFlagStrobe = processorRequest & controlOk;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      parityErrorFlag <= 1'b0;
    end else begin
      parityErrorFlag <= errorFlagStrobe & badParityDetected & errorReportEnableBit;
    end
  end
  // ==========================================================
  // Write parity generator with transparent-latch behaviour
  logic [1:0] genOdd;
  logic [1:0] next_parity;
  for (g = 0; g < 2; g++) begin : gen_par
    mbpu_byte_parity u_gen (
      .dataByte(writeData[g*8 +: 8]),
      .extraBit(forceBadParityBit),
      .oddOut(genOdd[g])
    );
  end
  // Bit 16 low byte, bit 17 high byte; byte write only touches bit 16
  always_comb begin
    next_parity = memParityOut;
    if (!dataLatchControl) begin
      next_parity[0] = genOdd[0];
      if (!writeByte) begin
        next_parity[1] = genOdd[1];
      end
    end
  end
  // Register stands in for the latch: tracks while low, holds once high
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      memParityOut <= 2'h0;
    end else begin
      memParityOut <= next_parity;
    end
  end
  // ==========================================================
  // Assertions
  property p_ack;
    @(posedge clk_sys) disable iff (!rst_n)
      accessOk |=> registerAcknowledge;
  endproperty
  a_ack: assert property (p_ack) else $error("no acknowledge on hit");
  property p_jumper_block;
    @(posedge clk_sys) disable iff (!rst_n)
      jmpStable[4] |=> !registerAcknowledge;
  endproperty
  a_jumper_block: assert property (p_jumper_block) else $error("access with jumper in");
  property p_strobe_write;
    @(posedge clk_sys) disable iff (!rst_n)
      registerWriteStrobe |-> $past(isWrite) && $past(accessOk);
  endproperty
  a_strobe_write: assert property (p_strobe_write) else $error("strobe without write");
  property p_enable_load;
    @(posedge clk_sys) disable iff (!rst_n)
      writeNow |=> errorReportEnableBit == $past(busDataIn[0]);
  endproperty
  a_enable_load: assert property (p_enable_load) else $error("enable bit not loaded");
  property p_force_load;
    @(posedge clk_sys) disable iff (!rst_n)
      writeNow |=> forceBadParityBit == $past(busDataIn[2]);
  endproperty
  a_force_load: assert property (p_force_load) else $error("force bit not loaded");
  property p_err_set;
    @(posedge clk_sys) disable iff (!rst_n)
      errorSeenSet |=> errorSeenBit;
  endproperty
  a_err_set: assert property (p_err_set) else $error("error seen not set");
  property p_err_only_done;
    @(posedge clk_sys) disable iff (!rst_n)
      (!errorSeenBit ##1 errorSeenBit) |-> $past(writeNow) || $past(cycleDone && !doneSeen);
  endproperty
  a_err_only_done: assert property (p_err_only_done) else $error("error seen set early");
  property p_flag_gate;
    @(posedge clk_sys) disable iff (!rst_n)
      parityErrorFlag |-> $past(errorReportEnableBit) && $past(controlOk) && $past(processorRequest);
  endproperty
  a_flag_gate: assert property (p_flag_gate) else $error("flag without gating");
  property p_hold_latch;
    @(posedge clk_sys) disable iff (!rst_n)
      (dataLatchControl ##1 dataLatchControl) |-> $stable(memParityOut);
  endproperty
  a_hold_latch: assert property (p_hold_latch) else $error("parity changed while latched");
  property p_strobe_pulse;
    @(posedge clk_sys) disable iff (!rst_n)
      registerWriteStrobe |=> !registerWriteStrobe;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("write strobe too long");
  property p_readback;
    @(posedge clk_sys) disable iff (!rst_n)
      registerReadGate |-> (busDataOut[mbpu_pkg::MBPU_BIT_REPORT_EN] == $past(errorReportEnableBit))
        && (busDataOut[mbpu_pkg::MBPU_BIT_ERR_SEEN] == $past(errorSeenBit));
  endproperty
  a_readback: assert property (p_readback) else $error("read data not register");
  property p_flag_request;
    @(posedge clk_sys) disable iff (!rst_n)
      !processorRequest |=> !parityErrorFlag;
  endproperty
  a_flag_request: assert property (p_flag_request) else $error("flag without request");
  c_force: cover property (@(posedge clk_sys) disable iff (!rst_n)
    forceBadParityBit && !dataLatchControl);
  c_write: cover property (@(posedge clk_sys) disable iff (!rst_n) registerWriteStrobe);
  c_read: cover property (@(posedge clk_sys) disable iff (!rst_n) registerReadGate);
  c_flag: cover property (@(posedge clk_sys) disable iff (!rst_n) parityErrorFlag);
  c_seen: cover property (@(posedge clk_sys) disable iff (!rst_n) errorSeenSet);
endmodule : mbpu_parity_unit

// ---- mbpu_pkg.sv ----
// Purpose: Shared constants for the memory byte parity unit
// Assumes: Register sits on a 16-bit word bus with an 18-bit address
// Notes: Fixed high address pattern covers bits 17 down to 5
package mbpu_pkg;
  // ==========================================================
  // Register address decode
  localparam logic [12:0] MBPU_ADDR_HIGH = 13'h1FA2;
  localparam int MBPU_ADDR_HIGH_LSB = 5;
  localparam int MBPU_ADDR_SEL_LSB = 2;
  // ==========================================================
  // Register field positions
  localparam int MBPU_BIT_REPORT_EN = 0;
  localparam int MBPU_BIT_FORCE_BAD = 2;
  localparam int MBPU_BIT_ERR_SEEN = 15;
  // ==========================================================
  // Reset values
  localparam logic MBPU_RST_REPORT_EN = 1'b0;
  localparam logic MBPU_RST_FORCE_BAD = 1'b0;
  localparam logic MBPU_RST_ERR_SEEN = 1'b0;
  // ==========================================================
  // Bus cycle types
  typedef enum logic [1:0] {MBPU_CYC_READ, MBPU_CYC_READ_PAUSE, MBPU_CYC_WRITE,
    MBPU_CYC_WRITE_BYTE} mbpu_cycle_e;
endpackage : mbpu_pkg

// ---- mbpu_proc_model.sv ----
// Purpose: Processor side of fast-bus reads for the parity unit
// Assumes: One read cycle at a time, started by the bench
// Notes: Released read data turns to its inverse so stale values never pass
`timescale 1ns/1ns
module mbpu_proc_model (
  input wire logic clk_sys,
  input wire logic parityErrorFlag,
  output logic processorRequest,
  output logic controlOk,
  output logic fastRead,
  output logic dataLatchControl,
  output logic cycleDone,
  output logic [17:0] memReadData,
  output logic [8:0] trapAddr
);
  // ==========================================================
  // Idle levels
  initial begin
    {processorRequest, controlOk, fastRead, dataLatchControl, cycleDone} = 5'h00;
    memReadData = 18'h3FFFF;
    trapAddr = 9'h000;
  end
  // Latch hold for the write path
  task automatic setLatch(input logic v);
    @(posedge clk_sys);
    dataLatchControl <= v;
  endtask : setLatch
  // One read; fast low stands for a Unibus read with no request or control ok
  task automatic readCycle(input logic [17:0] rd, input logic fast);
    @(posedge clk_sys);
    {processorRequest, controlOk, fastRead} <= {3{fast}};
    memReadData <= rd;
    trapAddr <= 9'h000;
    repeat (2) @(posedge clk_sys);
    dataLatchControl <= 1'b1;
    repeat (2) @(posedge clk_sys);
    cycleDone <= 1'b1;
    repeat (3) @(posedge clk_sys);
    // Flag fluctuates while control ok stands, so it counts only as that drops
    controlOk <= 1'b0;
    if (controlOk && parityErrorFlag) trapAddr <= 9'h04C;
    @(posedge clk_sys);
    {processorRequest, fastRead, dataLatchControl, cycleDone} <= 4'h0;
    memReadData <= ~rd;
  endtask : readCycle
endmodule : mbpu_proc_model

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the memory byte parity unit
// Assumes: Base jumpers 3'h5, low-select jumper cut, so bit 1 is one
// Notes: Expected values worked out by hand from the parity rules
`timescale 1ns/1ns
module tb_top;
  localparam logic [17:0] RA = {mbpu_pkg::MBPU_ADDR_HIGH, 3'h5, 1'b1, 1'b0};
  logic clk_sys, rst_n, sync, enJmp, lowJmp, wrByte, processor_request, cOk, fRd, dLat, cDone, flag;
  logic ack, gate, stb, seen, forceBit, en;
  logic [17:0] addr, rdData;
  logic [15:0] din, wdata, dout;
  logic [1:0] par;
  logic [8:0] trapAddr;
  mbpu_pkg::mbpu_cycle_e cyc;
  int numErrors = 0;
  int testsRun = 0;
  mbpu_parity_unit mbpu_parity_unit_inst (.clk_sys(clk_sys), .rst_n(rst_n), .busAddr(addr),
    .busDataIn(din), .busCycle(cyc), .masterSyncDerivative(sync),
    .baseSelectLevelsPin(3'h5), .lowSelectJumperInPin(lowJmp), .enableJumperInPin(enJmp),
    .writeData(wdata), .writeByte(wrByte), .dataLatchControl(dLat), .memReadData(rdData),
    .fastRead(fRd), .cycleDone(cDone), .processorRequest(processor_request), .controlOk(cOk),
    .busDataOut(dout), .registerReadGate(gate), .registerAcknowledge(ack),
    .registerWriteStrobe(stb), .memParityOut(par), .parityErrorFlag(flag),
    .errorSeenBit(seen), .forceBadParityBit(forceBit), .errorReportEnableBit(en));
  mbpu_proc_model mbpu_proc_model_inst (.clk_sys(clk_sys), .parityErrorFlag(flag),
    .processorRequest(processor_request), .controlOk(cOk), .fastRead(fRd), .dataLatchControl(dLat),
    .cycleDone(cDone), .memReadData(rdData), .trapAddr(trapAddr));
  // ==========================================================
  // Compare, verdict and register access
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    testsRun++;
    if (got !== exp) begin
      numErrors++;
      $display("Error at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("TB: %0d compares, %0d mismatches", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  // Sync held three cycles, then dropped so the next access is a fresh one
  task automatic acc(input logic [17:0] a, input mbpu_pkg::mbpu_cycle_e c,
    input logic [15:0] d, input logic eAck, input logic [15:0] eRd);
    logic isRd;
    isRd = (c == mbpu_pkg::MBPU_CYC_READ) || (c == mbpu_pkg::MBPU_CYC_READ_PAUSE);
    @(posedge clk_sys);
    addr <= a;
    cyc <= c;
    din <= d;
    sync <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk(stb, eAck && c == mbpu_pkg::MBPU_CYC_WRITE);
    @(posedge clk_sys);
    #1;
    chk(stb, 1'b0);
    chk(ack, eAck);
    chk(gate, eAck && isRd);
    if (isRd) chk(dout, eRd);
    @(posedge clk_sys);
    sync <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : acc
  task automatic wp(input logic [15:0] d, input logic b, input logic [1:0] e);
    @(posedge clk_sys);
    {wdata, wrByte} <= {d, b};
    repeat (2) @(posedge clk_sys);
    #1;
    chk(par, e);
  endtask : wp
  // ==========================================================
  // Clock and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    #40000;
    numErrors++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end
  // ==========================================================
  // Tests
  initial begin
    logic [17:0] badA [4];
    mbpu_pkg::mbpu_cycle_e bc [4];
    logic [17:0] rd [4];
    badA = '{RA ^ 18'h20000, RA ^ 18'h00010, RA ^ 18'h00002, RA};
    bc = '{mbpu_pkg::MBPU_CYC_WRITE, mbpu_pkg::MBPU_CYC_READ, mbpu_pkg::MBPU_CYC_WRITE,
      mbpu_pkg::MBPU_CYC_WRITE_BYTE};
    rd = '{18'h10301, 18'h00301, 18'h30301, 18'h00301};
    {rst_n, sync, enJmp, lowJmp, wrByte, addr, din, wdata} = '0;
    cyc = mbpu_pkg::MBPU_CYC_READ;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk({seen, forceBit, en, flag}, 4'h0);
    $display("TB: reset test done");
    acc(RA, mbpu_pkg::MBPU_CYC_WRITE, 16'hFFFF, 1'b1, 16'h0000);
    chk({seen, forceBit, en}, 3'h7);
    acc(RA, mbpu_pkg::MBPU_CYC_READ, 16'h0000, 1'b1, 16'h8005);
    // Wrong high bits, wrong base, wrong bit 1, byte write: none may load
    for (int i = 0; i < 4; i++) begin
      acc(badA[i], bc[i], 16'h0000, i == 3, 16'h0000);
      chk({seen, forceBit, en}, 3'h7);
    end
    enJmp <= 1'b1;
    repeat (6) @(posedge clk_sys);
    acc(RA, mbpu_pkg::MBPU_CYC_WRITE, 16'h0000, 1'b0, 16'h0000);
    chk({seen, forceBit, en}, 3'h7);
    enJmp <= 1'b0;
    repeat (6) @(posedge clk_sys);
    // Low-select jumper installed: bit 1 must now be zero
    lowJmp <= 1'b1;
    repeat (6) @(posedge clk_sys);
    acc(RA ^ 18'h00002, mbpu_pkg::MBPU_CYC_READ_PAUSE, 16'h0000, 1'b1, 16'h8005);
    acc(RA, mbpu_pkg::MBPU_CYC_READ, 16'h0000, 1'b0, 16'h0000);
    lowJmp <= 1'b0;
    repeat (6) @(posedge clk_sys);
    $display("TB: register access test done");
    acc(RA, mbpu_pkg::MBPU_CYC_WRITE, 16'h0000, 1'b1, 16'h0000);
    wp(16'h0301, 1'b0, 2'h1);
    wp(16'h0103, 1'b1, 2'h0);
    mbpu_proc_model_inst.setLatch(1'b1);
    wp(16'h0301, 1'b0, 2'h0);
    mbpu_proc_model_inst.setLatch(1'b0);
    acc(RA, mbpu_pkg::MBPU_CYC_WRITE, 16'h0004, 1'b1, 16'h0000);
    wp(16'h0301, 1'b0, 2'h2);
    $display("TB: write parity test done");
    // Good word, bad low byte, bad high byte unreported, Unibus read of bad data
    for (int i = 0; i < 4; i++) begin
      acc(RA, mbpu_pkg::MBPU_CYC_WRITE, {15'h0000, i != 2}, 1'b1, 16'h0000);
      mbpu_proc_model_inst.readCycle(rd[i], i != 3);
      chk(trapAddr, (i == 1) ? 9'h04C : 9'h000);
      acc(RA, mbpu_pkg::MBPU_CYC_READ, 16'h0000, 1'b1, {i == 1 || i == 2, 14'h0000,
        i != 2});
    end
    $display("TB: read check test done");
    end_sim();
  end
endmodule : tb_top
